//--- verilog/vrlis_pkg.sv
`default_nettype none
package vrlis_pkg;
    localparam int unsigned N_SRC       = 9;
    localparam int unsigned ADDR_W      = 12;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned IDX_W       = 8;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_STATUS_TWO   = 8'h66;
    localparam logic [7:0] IDX_STATUS_THREE = 8'h6B;
    localparam logic [7:0] IDX_STATUS_FOUR  = 8'h70;
    localparam logic [7:0] IDX_MASK         = 8'h74;
    localparam logic [7:0] IDX_CLEAR        = 8'h75;
    localparam logic [7:0] IDX_PENDING      = 8'h76;

    // source slots in the internal status vector
    localparam int unsigned SRC_GCP   = 0;
    localparam int unsigned SRC_ACR   = 1;
    localparam int unsigned SRC_GAMUT = 2;
    localparam int unsigned SRC_PLL   = 3;
    localparam int unsigned SRC_CLK   = 4;
    localparam int unsigned SRC_STEREO = 5;
    localparam int unsigned SRC_VSYNC = 6;
    localparam int unsigned SRC_DE    = 7;
    localparam int unsigned SRC_ENC   = 8;

    // field positions inside the byte-wide status registers
    localparam int unsigned POS_GCP    = 2;
    localparam int unsigned POS_ACR    = 1;
    localparam int unsigned POS_GAMUT  = 0;
    localparam int unsigned POS_PLL    = 6;
    localparam int unsigned POS_CLK    = 4;
    localparam int unsigned POS_STEREO = 2;
    localparam int unsigned POS_VSYNC  = 1;
    localparam int unsigned POS_DE     = 0;
    localparam int unsigned POS_ENC    = 2;

    localparam logic [8:0]  RST_STATUS = 9'h000;
    localparam logic [8:0]  RST_MASK   = 9'h000;
    localparam logic [31:0] RST_RDATA  = 32'h0000_0000;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } vrlis_bus_t;
endpackage : vrlis_pkg
`default_nettype wire

//--- verilog/vrlis_evt_if.sv
`timescale 1ns/10ps
`default_nettype none
interface vrlis_evt_if;
    import vrlis_pkg::*;
    logic [N_SRC-1:0] raw;
    logic [N_SRC-1:0] clear;
    logic [N_SRC-1:0] change;
    logic [N_SRC-1:0] status;

    modport ctl (output raw, output clear, input change, input status);
    modport lat (input raw, input clear, output change, output status);
endinterface : vrlis_evt_if
`default_nettype wire

//--- verilog/vrlis_latch.sv
`timescale 1ns/10ps
`default_nettype none
module vrlis_latch (
    input  wire logic    clk,
    input  wire logic    resetn,
    input  wire logic    ce,
    vrlis_evt_if.lat     ev
);
    import vrlis_pkg::*;

    logic [N_SRC-1:0] prev_r;
    logic [N_SRC-1:0] prev_nxt;
    logic [N_SRC-1:0] status_r;
    logic [N_SRC-1:0] status_nxt;
    logic             primed_r;

    genvar i;
    generate
        for (i = 0; i < N_SRC; i++) begin : g_src
            // no change seen until a first sample of the raw level exists
            assign ev.change[i] = primed_r & (ev.raw[i] ^ prev_r[i]);
            // set beats clear so a coincident event is kept
            always_comb begin
                status_nxt[i] = (status_r[i] & ~ev.clear[i]) | ev.change[i];
                prev_nxt[i]   = ev.raw[i];
            end
        end
    endgenerate

    assign ev.status = status_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            status_r <= RST_STATUS;
            prev_r   <= RST_STATUS;
            primed_r <= 1'b0;
        end else if (ce) begin
            status_r <= status_nxt;
            prev_r   <= prev_nxt;
            primed_r <= 1'b1;
        end
    end
endmodule : vrlis_latch
`default_nettype wire

//--- verilog/vrlis_top.sv
// Local design decision: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module vrlis_top (
    input  wire logic                        clk,
    input  wire logic                        resetn,
    input  wire logic                        ce,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [vrlis_pkg::ADDR_W-1:0] paddr,
    input  wire logic [vrlis_pkg::DATA_W-1:0] pwdata,
    output logic      [vrlis_pkg::DATA_W-1:0] prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        general_control_packet_raw,
    input  wire logic                        audio_clock_regen_raw,
    input  wire logic                        gamut_metadata_raw,
    input  wire logic                        port_a_pll_lock_raw,
    input  wire logic                        port_a_link_clock_raw,
    input  wire logic                        stereo_video_raw,
    input  wire logic                        vsync_filter_lock_raw,
    input  wire logic                        de_regeneration_lock_raw,
    input  wire logic                        port_a_encryption_raw,
    output logic                             first_interrupt_output
);
    import vrlis_pkg::*;

    vrlis_evt_if ev ();

    vrlis_bus_t          bus_r;
    vrlis_bus_t          bus_nxt;
    logic                pready_r;
    logic                pready_nxt;
    logic                pslverr_r;
    logic                pslverr_nxt;
    logic [DATA_W-1:0]   prdata_r;
    logic [DATA_W-1:0]   prdata_nxt;
    logic [N_SRC-1:0]    mask_r;
    logic [N_SRC-1:0]    mask_nxt;
    logic                irq_r;
    logic                irq_nxt;
    logic [N_SRC-1:0]    clear_pulse;
    logic [N_SRC-1:0]    status;
    logic [N_SRC-1:0]    pending;
    logic [IDX_W-1:0]    idx;
    logic                aligned;
    logic                hit;
    logic                is_status;
    logic                access;
    logic                wr_done;
    logic [DATA_W-1:0]   rd_word;

    // raw levels come from logic on this clock, so no synchroniser
    assign ev.raw = {port_a_encryption_raw,
                     de_regeneration_lock_raw,
                     vsync_filter_lock_raw,
                     stereo_video_raw,
                     port_a_link_clock_raw,
                     port_a_pll_lock_raw,
                     gamut_metadata_raw,
                     audio_clock_regen_raw,
                     general_control_packet_raw};
    assign ev.clear = clear_pulse;
    assign status   = ev.status;

    vrlis_latch u_latch (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .ev     (ev)
    );

    assign pending = status & mask_r;

    // address decode: index sits in paddr[9:2], upper bits must be zero
    assign idx     = paddr[9:2];
    assign aligned = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
    assign is_status = (idx == IDX_STATUS_TWO) || (idx == IDX_STATUS_THREE)
                    || (idx == IDX_STATUS_FOUR);
    assign hit = aligned && (is_status || (idx == IDX_MASK)
              || (idx == IDX_CLEAR) || (idx == IDX_PENDING));
    assign access  = psel && penable && pready_r;
    assign wr_done = access && pwrite && hit;

    always_comb begin
        rd_word = RST_RDATA;
        if (aligned) begin
            case (idx)
                IDX_STATUS_TWO: begin
                    rd_word[POS_GCP]   = status[SRC_GCP];
                    rd_word[POS_ACR]   = status[SRC_ACR];
                    rd_word[POS_GAMUT] = status[SRC_GAMUT];
                end
                IDX_STATUS_THREE: begin
                    rd_word[POS_PLL]    = status[SRC_PLL];
                    rd_word[POS_CLK]    = status[SRC_CLK];
                    rd_word[POS_STEREO] = status[SRC_STEREO];
                    rd_word[POS_VSYNC]  = status[SRC_VSYNC];
                    rd_word[POS_DE]     = status[SRC_DE];
                end
                IDX_STATUS_FOUR: begin
                    rd_word[POS_ENC] = status[SRC_ENC];
                end
                IDX_MASK: begin
                    rd_word[N_SRC-1:0] = mask_r;
                end
                IDX_PENDING: begin
                    rd_word[N_SRC-1:0] = pending;
                end
                default: begin
                    rd_word = RST_RDATA;
                end
            endcase
        end
    end

    // clear register is write-one-to-clear and always reads zero
    always_comb begin
        clear_pulse = '0;
        if (wr_done && (idx == IDX_CLEAR)) begin
            clear_pulse = pwdata[N_SRC-1:0];
        end
    end

    // one wait state; read data is sampled at the first access cycle,
    // so an event in that cycle shows on the next read
    always_comb begin
        bus_nxt     = bus_r;
        pready_nxt  = 1'b0;
        pslverr_nxt = 1'b0;
        prdata_nxt  = prdata_r;
        mask_nxt    = mask_r;
        case (bus_r)
            BUS_IDLE: begin
                if (psel && penable) begin
                    bus_nxt     = BUS_ACK;
                    pready_nxt  = 1'b1;
                    pslverr_nxt = !hit;
                    prdata_nxt  = pwrite ? RST_RDATA : rd_word;
                end
            end
            BUS_ACK: begin
                bus_nxt = BUS_IDLE;
            end
            default: begin
                bus_nxt = BUS_IDLE;
            end
        endcase
        // writes to status or pending indices are dropped
        if (wr_done && (idx == IDX_MASK)) begin
            mask_nxt = pwdata[N_SRC-1:0];
        end
        irq_nxt = |pending;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            bus_r     <= BUS_IDLE;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= RST_RDATA;
            mask_r    <= RST_MASK;
            irq_r     <= 1'b0;
        end else if (ce) begin
            bus_r     <= bus_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
            mask_r    <= mask_nxt;
            irq_r     <= irq_nxt;
        end
    end

    assign prdata                 = prdata_r;
    assign pready                 = pready_r;
    assign pslverr                = pslverr_r;
    assign first_interrupt_output = irq_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_sets(int b);
        (ce && ev.change[b]) |=> status[b];
    endproperty

    chk_hold_until_clear: assert property (
        (ce && (status != '0)) |=>
            ((~status & $past(status) & ~$past(clear_pulse)) == '0))
        else $error("status bit dropped without its clear");

    chk_masked_no_irq: assert property (
        (ce && (pending == '0)) |=> !first_interrupt_output)
        else $error("interrupt raised with all pending sources masked");

    chk_gcp_sets: assert property (p_sets(SRC_GCP))
        else $error("general control packet change not latched");

    chk_acr_sets: assert property (p_sets(SRC_ACR))
        else $error("audio clock regen change not latched");

    chk_gamut_sets: assert property (p_sets(SRC_GAMUT))
        else $error("gamut metadata change not latched");

    chk_pll_sets: assert property (p_sets(SRC_PLL))
        else $error("pll lock change not latched");

    chk_clk_sets: assert property (p_sets(SRC_CLK))
        else $error("link clock change not latched");

    chk_stereo_sets: assert property (p_sets(SRC_STEREO))
        else $error("stereo video change not latched");

    chk_vsync_sets: assert property (p_sets(SRC_VSYNC))
        else $error("vsync lock change not latched");

    chk_de_sets: assert property (p_sets(SRC_DE))
        else $error("de regeneration change not latched");

    chk_enc_sets: assert property (p_sets(SRC_ENC))
        else $error("encryption change not latched");

    chk_reset_zero: assert property (
        @(posedge clk) disable iff (1'b0)
        !resetn |=> (status == '0) && !first_interrupt_output)
        else $error("status not zero after reset");

    chk_status_ro: assert property (
        (ce && wr_done && is_status && (clear_pulse == '0)
         && (ev.change == '0)) |=> $stable(status))
        else $error("write to status register altered status");

    chk_set_wins: assert property (
        (ce && ((clear_pulse & ev.change) != '0)) |=>
            ((($past(clear_pulse) & $past(ev.change)) & ~status) == '0))
        else $error("coincident change lost to clear");

    chk_ready_one: assert property (
        (ce && pready) ##1 ce |-> !pready)
        else $error("pready held for more than one cycle");

    cov_irq_rise: cover property ($rose(first_interrupt_output));
    cov_clear_bit: cover property (ce && ((clear_pulse & status) != '0));
    cov_set_clear: cover property (ce && ((clear_pulse & ev.change) != '0));
    cov_read_three: cover property (access && !pwrite
                                    && (idx == IDX_STATUS_THREE));
endmodule : vrlis_top
`default_nettype wire

//--- tb/video_rx_level_irq_status_bench.sv
`timescale 1ns/10ps
`default_nettype none
module video_rx_level_irq_status_bench;
    import vrlis_pkg::*;
    localparam logic [ADDR_W-1:0] A_TWO   = ADDR_W'(IDX_STATUS_TWO) << 2;
    localparam logic [ADDR_W-1:0] A_THREE = ADDR_W'(IDX_STATUS_THREE) << 2;
    localparam logic [ADDR_W-1:0] A_FOUR  = ADDR_W'(IDX_STATUS_FOUR) << 2;
    localparam logic [ADDR_W-1:0] A_MASK  = ADDR_W'(IDX_MASK) << 2;
    localparam logic [ADDR_W-1:0] A_CLR   = ADDR_W'(IDX_CLEAR) << 2;
    localparam logic [ADDR_W-1:0] A_PEND  = ADDR_W'(IDX_PENDING) << 2;
    localparam logic [ADDR_W-1:0] RST_ADDRS [4] =
        '{A_TWO, A_THREE, A_FOUR, A_MASK};
    logic              ce      = 1'b1;
    logic              clk     = 1'b0;
    logic              resetn  = 1'b0;
    logic              psel    = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite  = 1'b0;
    logic [ADDR_W-1:0] paddr   = 12'h000;
    logic [DATA_W-1:0] pwdata  = 32'h0000_0000;
    logic [N_SRC-1:0]  raw     = 9'h000;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              irq;
    logic [N_SRC-1:0]  st_m;
    logic [N_SRC-1:0]  mk_m;
    logic [N_SRC-1:0]  rp_m;
    logic              first_m;
    logic              irq_m;
    logic [DATA_W-1:0] rd;
    logic              err;
    int                error_cnt   = 0;
    int                comparisons = 0;
    int                seed        = 73;
    wire logic         done = psel & penable & pready & pwrite;

    always #5 clk = ~clk;

    vrlis_top dut (
        .clk(clk), .resetn(resetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .general_control_packet_raw(raw[SRC_GCP]),
        .audio_clock_regen_raw(raw[SRC_ACR]),
        .gamut_metadata_raw(raw[SRC_GAMUT]),
        .port_a_pll_lock_raw(raw[SRC_PLL]),
        .port_a_link_clock_raw(raw[SRC_CLK]),
        .stereo_video_raw(raw[SRC_STEREO]),
        .vsync_filter_lock_raw(raw[SRC_VSYNC]),
        .de_regeneration_lock_raw(raw[SRC_DE]),
        .port_a_encryption_raw(raw[SRC_ENC]),
        .first_interrupt_output(irq)
    );

    task automatic check(input string nm, input logic [DATA_W-1:0] seen,
                         input logic [DATA_W-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // reference latches; a change on the clearing edge wins
    always @(posedge clk) begin
        if (resetn) begin
            check("irq", {31'h0, irq}, {31'h0, irq_m});
        end
        if (!resetn) begin
            st_m    <= 9'h000;
            mk_m    <= 9'h000;
            irq_m   <= 1'b0;
            first_m <= 1'b1;
        end else if (ce) begin
            first_m <= 1'b0;
            rp_m    <= raw;
            irq_m   <= |(st_m & mk_m);
            st_m    <= (st_m & ~((done && paddr == A_CLR) ?
                        pwdata[N_SRC-1:0] : 9'h000)) |
                       (first_m ? 9'h000 : raw ^ rp_m);
            if (done && paddr == A_MASK) begin
                mk_m <= pwdata[N_SRC-1:0];
            end
        end
    end

    function automatic logic [DATA_W-1:0] pack(input int r,
                                               input logic [N_SRC-1:0] s);
        logic [DATA_W-1:0] v;
        v = 32'h0000_0000;
        if (r == 2) begin
            v[POS_GCP]   = s[SRC_GCP];
            v[POS_ACR]   = s[SRC_ACR];
            v[POS_GAMUT] = s[SRC_GAMUT];
        end else if (r == 3) begin
            v[POS_PLL]    = s[SRC_PLL];
            v[POS_CLK]    = s[SRC_CLK];
            v[POS_STEREO] = s[SRC_STEREO];
            v[POS_VSYNC]  = s[SRC_VSYNC];
            v[POS_DE]     = s[SRC_DE];
        end else begin
            v[POS_ENC] = s[SRC_ENC];
        end
        return v;
    endfunction : pack

    // tog flips raw so its change lands on the completing edge
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input logic [N_SRC-1:0] tog);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (n == 1 && !pready) raw <= raw ^ tog;
        end while (!pready && n < 50);
        check("pready", {31'h0, pready}, 32'h1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic read_all();
        apb(1'b0, A_TWO, 32'h0, 9'h000);
        check("status_two", rd, pack(2, st_m));
        apb(1'b0, A_THREE, 32'h0, 9'h000);
        check("status_three", rd, pack(3, st_m));
        apb(1'b0, A_FOUR, 32'h0, 9'h000);
        check("status_four", rd, pack(4, st_m));
        apb(1'b0, A_PEND, 32'h0, 9'h000);
        check("pending", rd, {23'h0, st_m & mk_m});
    endtask : read_all

    task automatic report_and_stop();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, RST_ADDRS[k], 32'h0, 9'h000);
            check("after reset", rd, 32'h0);
        end
        apb(1'b0, 12'h004, 32'h0, 9'h000);
        check("unmapped err", {31'h0, err}, 32'h1);
        apb(1'b1, 12'h004, 32'hFFFF_FFFF, 9'h000);
        check("unmapped werr", {31'h0, err}, 32'h1);
        // misaligned offset of a mapped index must still be refused
        apb(1'b0, A_MASK | 12'h001, 32'h0, 9'h000);
        check("misaligned err", {31'h0, err}, 32'h1);
        check("misaligned rd", rd, 32'h0);
        apb(1'b1, A_MASK, 32'h0000_01FF, 9'h000);
        apb(1'b0, A_MASK, 32'h0, 9'h000);
        check("mask", rd, 32'h0000_01FF);
        for (int i = 0; i < N_SRC; i++) begin
            apb(1'b1, A_TWO, 32'hFFFF_FFFF, 9'h000);
            apb(1'b1, A_THREE, 32'hFFFF_FFFF, 9'h000);
            apb(1'b1, A_FOUR, 32'hFFFF_FFFF, 9'h000);
            apb(1'b0, A_PEND, 32'h0, 9'h000);
            check("ro status", rd, 32'h0);
            raw <= raw ^ (9'h001 << i);
            read_all();
            raw <= raw ^ (9'h001 << i);
            repeat (2 + ($unsigned($random(seed)) % 8)) @(posedge clk);
            apb(1'b1, A_MASK, 32'h0000_01FF, 9'h000);
            apb(1'b0, A_PEND, 32'h0, 9'h000);
            check("held", {31'h0, rd[i]}, 32'h1);
            apb(1'b1, A_CLR, 32'h1 << i, 9'h001 << i);
            apb(1'b0, A_PEND, 32'h0, 9'h000);
            check("kept on clear", {31'h0, rd[i]}, 32'h1);
            apb(1'b1, A_CLR, 32'h1 << i, 9'h000);
            read_all();
        end
        apb(1'b1, A_MASK, 32'h0, 9'h000);
        raw <= ~raw;
        repeat (3) @(posedge clk);
        check("masked irq", {31'h0, irq}, 32'h0);
        read_all();
        for (int j = 0; j < 40; j++) begin
            raw <= raw ^ 9'($random(seed));
            apb(1'b1, A_MASK, $random(seed), 9'h000);
            apb(1'b1, A_CLR, $random(seed), 9'($random(seed)));
            apb(1'b1, A_THREE, $random(seed), 9'h000);
            apb(1'b0, A_CLR, 32'h0, 9'h000);
            check("clear reads", rd, 32'h0);
            read_all();
        end
        // frozen clock enable: raw moves but nothing is sampled until ce
        ce  <= 1'b0;
        raw <= ~raw;
        repeat (4) @(posedge clk);
        ce  <= 1'b1;
        read_all();
        // reset must act even while ce is low
        resetn <= 1'b0;
        ce     <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        ce     <= 1'b1;
        read_all();
        apb(1'b0, A_MASK, 32'h0, 9'h000);
        check("mask after reset", rd, 32'h0);
        report_and_stop();
    end
endmodule : video_rx_level_irq_status_bench
`default_nettype wire
